//--- src/gpicfg_core.sv
// gpicfg_core: pull selection, level selection and fifo routing of the general inputs
`timescale 1ns/1ps
// How it works
// - pull code 00 300k up, 01 300k down, 10 100k up, 11 none.
// - columns 3..0 in bits 7:0 of 0x19; column 4 bits 1:0 of 0x1a.
// - level bit 0 sets input status while its pin is low.
// - level bit 1 sets input status while its pin is high.
// - inputs 1..6 watch row pins 0..5; inputs 7..11 watch pins 6..10.
// - level bits inputs 1..6 at 0x1b[5:0], inputs 7..11 at 0x1c[4:0].
// - route bit 0 means no fifo events from that input.
// - route bit 1 records input activity as fifo events.
// - route bits inputs 1..6 at 0x1d[5:0], inputs 7..11 at 0x1e[4:0].
// - fifo-routed input activity raises the event interrupt.
// - fifo-routed inputs never raise the general-input interrupt flag.
// - fifo-routed input events are eligible for the unlock sequence.
// - enabled, set status and met condition assert general-input flag.
module gpicfg_core
  import gpicfg_pkg::*;
#(
  parameter int unsigned N_IN = GPICFG_N_IN,
  parameter int unsigned N_COL = GPICFG_N_COL
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [N_IN-1:0] gpi_pin,
  input wire logic [N_IN-1:0] input_irq_enable,
  input wire logic [N_IN-1:0] input_irq_clear,
  output logic [N_IN-1:0] input_irq_status,
  output logic general_input_irq_flag,
  output logic [N_COL-1:0] column_pull_up_300k,
  output logic [N_COL-1:0] column_pull_down_300k,
  output logic [N_COL-1:0] column_pull_up_100k,
  output logic fifo_event_push,
  output logic [GPICFG_ID_W-1:0] fifo_event_input,
  output logic fifo_event_state,
  output logic fifo_event_unlock_ok,
  output logic event_irq_set
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [GPICFG_ID_W-1:0] lowest_set(input logic [N_IN-1:0] v);
    logic [GPICFG_ID_W-1:0] idx;
    idx = '0;
    for (int i = N_IN - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = GPICFG_ID_W'(i);
      end
    end
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] col_pull_lo_r;
  logic [7:0] col_pull_hi_r;
  logic [7:0] level_lo_r;
  logic [7:0] level_hi_r;
  logic [7:0] route_lo_r;
  logic [7:0] route_hi_r;
  logic [7:0] rdata_r;

  wire wr_cpl = reg_wr && (reg_addr == GPICFG_COL_PULL_LO_ADDR);
  wire wr_cph = reg_wr && (reg_addr == GPICFG_COL_PULL_HI_ADDR);
  wire wr_lvl = reg_wr && (reg_addr == GPICFG_LEVEL_LO_ADDR);
  wire wr_lvh = reg_wr && (reg_addr == GPICFG_LEVEL_HI_ADDR);
  wire wr_rtl = reg_wr && (reg_addr == GPICFG_ROUTE_LO_ADDR);
  wire wr_rth = reg_wr && (reg_addr == GPICFG_ROUTE_HI_ADDR);

  // unmapped addresses read zero
  wire [7:0] rd_mux =
    (reg_addr == GPICFG_COL_PULL_LO_ADDR) ? col_pull_lo_r :
    (reg_addr == GPICFG_COL_PULL_HI_ADDR) ? col_pull_hi_r :
    (reg_addr == GPICFG_LEVEL_LO_ADDR) ? level_lo_r :
    (reg_addr == GPICFG_LEVEL_HI_ADDR) ? level_hi_r :
    (reg_addr == GPICFG_ROUTE_LO_ADDR) ? route_lo_r :
    (reg_addr == GPICFG_ROUTE_HI_ADDR) ? route_hi_r : 8'h00;

  always_ff @(posedge clk) begin
    if (srst) begin
      col_pull_lo_r <= GPICFG_COL_PULL_LO_RST;
      col_pull_hi_r <= GPICFG_COL_PULL_HI_RST;
      level_lo_r <= GPICFG_LEVEL_RST;
      level_hi_r <= GPICFG_LEVEL_RST;
      route_lo_r <= GPICFG_ROUTE_RST;
      route_hi_r <= GPICFG_ROUTE_RST;
      rdata_r <= 8'h00;
    end else begin
      if (wr_cpl) col_pull_lo_r <= reg_wdata & GPICFG_COL_PULL_LO_MASK;
      if (wr_cph) col_pull_hi_r <= reg_wdata & GPICFG_COL_PULL_HI_MASK;
      if (wr_lvl) level_lo_r <= reg_wdata & GPICFG_LOW_MASK;
      if (wr_lvh) level_hi_r <= reg_wdata & GPICFG_HIGH_MASK;
      if (wr_rtl) route_lo_r <= reg_wdata & GPICFG_LOW_MASK;
      if (wr_rth) route_hi_r <= reg_wdata & GPICFG_HIGH_MASK;
      if (reg_rd) rdata_r <= rd_mux;
    end
  end
  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // column pulls
  // ----------------------------------------------------------------
  wire [2*N_COL-1:0] pull_codes = {col_pull_hi_r[1:0], col_pull_lo_r};
  for (genvar c = 0; c < N_COL; c++) begin : g_pull
    wire [1:0] code = pull_codes[2*c +: 2];
    assign column_pull_up_300k[c] = (code == GPICFG_PULL_UP_300K);
    assign column_pull_down_300k[c] = (code == GPICFG_PULL_DN_300K);
    assign column_pull_up_100k[c] = (code == GPICFG_PULL_UP_100K);
  end

  // ----------------------------------------------------------------
  // input levels and status
  // ----------------------------------------------------------------
  gpicfg_sync_if #(.N(N_IN)) sync_bus ();
  gpicfg_sync #(.N(N_IN)) u_sync (
    .clk(clk),
    .srst(srst),
    .pin(gpi_pin),
    .sync(sync_bus)
  );

  // input k+1 takes pin k, so the vectors line up bit for bit
  wire [N_IN-1:0] active_level = {level_hi_r[4:0], level_lo_r[5:0]};
  wire [N_IN-1:0] fifo_route = {route_hi_r[4:0], route_lo_r[5:0]};
  wire [N_IN-1:0] cond_met = ~(sync_bus.level ^ active_level);
  wire [N_IN-1:0] irq_path = ~fifo_route;

  logic [N_IN-1:0] status_r;
  logic flag_r;
  // a set in the clearing cycle survives the clear
  wire [N_IN-1:0] status_nxt = ((status_r & ~input_irq_clear) | cond_met) & irq_path;
  wire flag_nxt = |(input_irq_enable & status_nxt & cond_met & irq_path);

  always_ff @(posedge clk) begin
    if (srst) begin
      status_r <= '0;
      flag_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      flag_r <= flag_nxt;
    end
  end
  assign input_irq_status = status_r;
  assign general_input_irq_flag = flag_r;

  // ----------------------------------------------------------------
  // fifo events
  // ----------------------------------------------------------------
  // simultaneous changes queue here and leave one per cycle, lowest first
  logic [N_IN-1:0] pending_r;
  logic push_r;
  logic [GPICFG_ID_W-1:0] id_r;
  logic state_r;
  wire [GPICFG_ID_W-1:0] pick = lowest_set(pending_r);
  wire any_pending = |pending_r;
  wire [N_IN-1:0] grant = any_pending ? (N_IN'(1) << pick) : '0;
  wire [N_IN-1:0] pending_nxt = ((pending_r & ~grant) | sync_bus.change) & fifo_route;

  always_ff @(posedge clk) begin
    if (srst) begin
      pending_r <= '0;
      push_r <= 1'b0;
      id_r <= '0;
      state_r <= 1'b0;
    end else begin
      pending_r <= pending_nxt;
      push_r <= any_pending && fifo_route[pick];
      if (any_pending) begin
        id_r <= GPICFG_ID_W'(pick + 1'b1);
        state_r <= sync_bus.level[pick];
      end
    end
  end
  assign fifo_event_push = push_r;
  assign fifo_event_input = id_r;
  assign fifo_event_state = state_r;
  assign event_irq_set = push_r;
  assign fifo_event_unlock_ok = push_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_pull_decode: assert property (@(posedge clk) disable iff (srst)
    (col_pull_lo_r[1:0] == GPICFG_PULL_NONE) |->
      !(column_pull_up_300k[0] || column_pull_down_300k[0] || column_pull_up_100k[0]))
    else $error("column 0 pull active with code none");
  a_pull_hi_write: assert property (@(posedge clk) disable iff (srst)
    wr_cph |=> (col_pull_hi_r == ($past(reg_wdata) & GPICFG_COL_PULL_HI_MASK)))
    else $error("column 4 pull write wrong");
  a_reserved_read: assert property (@(posedge clk) disable iff (srst)
    reg_rd && (reg_addr == GPICFG_LEVEL_HI_ADDR) |=> (reg_rdata[7:5] == 3'h0))
    else $error("reserved level bits read nonzero");
  a_level_low_sets: assert property (@(posedge clk) disable iff (srst)
    (!active_level[0] && !sync_bus.level[0] && !fifo_route[0]) |=> status_r[0])
    else $error("low level did not set status");
  a_level_high_sets: assert property (@(posedge clk) disable iff (srst)
    (active_level[7] && sync_bus.level[7] && !fifo_route[7]) |=> status_r[7])
    else $error("high level did not set input 8 status");
  a_routed_no_flag: assert property (@(posedge clk) disable iff (srst)
    (fifo_route == {N_IN{1'b1}}) [*2] |-> !general_input_irq_flag)
    else $error("routed inputs raised general flag");
  a_routed_no_status: assert property (@(posedge clk) disable iff (srst)
    (input_irq_status & $past(fifo_route)) == '0)
    else $error("routed input shows interrupt status");
  a_flag_cause: assert property (@(posedge clk) disable iff (srst)
    general_input_irq_flag |-> $past(|(input_irq_enable & ~(sync_bus.level ^ active_level) & ~fifo_route)))
    else $error("general flag without cause");
  a_flag_raise: assert property (@(posedge clk) disable iff (srst)
    |(input_irq_enable & ~(sync_bus.level ^ active_level) & ~fifo_route) |=> general_input_irq_flag)
    else $error("enabled met condition gave no general flag");
  a_event_routed: assert property (@(posedge clk) disable iff (srst)
    (sync_bus.change[0] && fifo_route[0]) |=> ##[0:11] (fifo_event_push && event_irq_set))
    else $error("routed change produced no event");
  a_event_blocked: assert property (@(posedge clk) disable iff (srst)
    (fifo_route == '0) [*2] |-> !fifo_event_push)
    else $error("event from unrouted input");
endmodule

//--- src/gpicfg_pkg.sv
// gpicfg_pkg: register map, field layout and sizes of the input configuration block
package gpicfg_pkg;
  localparam int unsigned GPICFG_N_IN = 11;
  localparam int unsigned GPICFG_N_COL = 5;
  localparam int unsigned GPICFG_N_LOW = 6;
  localparam int unsigned GPICFG_N_HIGH = 5;
  localparam int unsigned GPICFG_SYNC_STAGES = 3;

  localparam logic [7:0] GPICFG_COL_PULL_LO_ADDR = 8'h19;
  localparam logic [7:0] GPICFG_COL_PULL_HI_ADDR = 8'h1a;
  localparam logic [7:0] GPICFG_LEVEL_LO_ADDR = 8'h1b;
  localparam logic [7:0] GPICFG_LEVEL_HI_ADDR = 8'h1c;
  localparam logic [7:0] GPICFG_ROUTE_LO_ADDR = 8'h1d;
  localparam logic [7:0] GPICFG_ROUTE_HI_ADDR = 8'h1e;

  localparam logic [7:0] GPICFG_COL_PULL_LO_MASK = 8'hff;
  localparam logic [7:0] GPICFG_COL_PULL_HI_MASK = 8'h03;
  localparam logic [7:0] GPICFG_LOW_MASK = 8'h3f;
  localparam logic [7:0] GPICFG_HIGH_MASK = 8'h1f;

  localparam logic [7:0] GPICFG_COL_PULL_LO_RST = 8'h00;
  localparam logic [7:0] GPICFG_COL_PULL_HI_RST = 8'h00;
  localparam logic [7:0] GPICFG_LEVEL_RST = 8'h00;
  localparam logic [7:0] GPICFG_ROUTE_RST = 8'h00;

  localparam int unsigned GPICFG_PULL_W = 2;
  localparam logic [1:0] GPICFG_PULL_UP_300K = 2'h0;
  localparam logic [1:0] GPICFG_PULL_DN_300K = 2'h1;
  localparam logic [1:0] GPICFG_PULL_UP_100K = 2'h2;
  localparam logic [1:0] GPICFG_PULL_NONE = 2'h3;

  localparam int unsigned GPICFG_ID_W = 4;
endpackage

//--- src/gpicfg_sync_if.sv
// gpicfg_sync_if: filtered input levels and change pulses between the synchroniser and the core
`timescale 1ns/1ps
interface gpicfg_sync_if #(parameter int unsigned N = 11);
  logic [N-1:0] level;
  logic [N-1:0] change;
  modport src (output level, output change);
  modport dst (input level, input change);
endinterface

//--- src/gpicfg_sync.sv
// gpicfg_sync: three-stage synchroniser with agreement filter for the input pins
`timescale 1ns/1ps
module gpicfg_sync
  import gpicfg_pkg::*;
#(
  parameter int unsigned N = GPICFG_N_IN
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [N-1:0] pin,
  gpicfg_sync_if.src sync
);
  logic [N-1:0] s1_r;
  logic [N-1:0] s2_r;
  logic [N-1:0] s3_r;
  logic [N-1:0] level_r;
  logic [N-1:0] change_r;
  wire [N-1:0] agree = ~(s2_r ^ s3_r);
  wire [N-1:0] level_nxt = (level_r & ~agree) | (s3_r & agree);

  // s1 only feeds s2; decisions look at stages two and three
  // idle pins sit high on their pull-ups: resetting to ones avoids a false change after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      level_r <= '1;
      change_r <= '0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
      change_r <= level_nxt ^ level_r;
    end
  end

  assign sync.level = level_r;
  assign sync.change = change_r;
endmodule

//--- verification/gpicfg_pin_model.sv
// gpicfg_pin_model: switches and signals on the input pins, prompt or slow
`timescale 1ns/1ps
module gpicfg_pin_model #(
  parameter int unsigned N = 11
) (
  input wire logic clk,
  input wire logic [N-1:0] target,
  input wire logic [3:0] lag,
  output logic [N-1:0] pin
);
  logic [3:0] cnt_r = 4'h0;
  initial pin = '1;
  // a slow source moves only after the request has stood lag cycles
  always @(negedge clk) begin
    if (target === pin) cnt_r <= 4'h0;
    else if (cnt_r >= lag) pin <= target;
    else cnt_r <= cnt_r + 4'h1;
  end
endmodule

//--- verification/testbench.sv
// testbench: register, pull, level and event checks of the input configuration block
`timescale 1ns/1ps
module testbench;
  import gpicfg_pkg::*;
  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic clk;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [10:0] target = '1;
  logic [10:0] irq_en = '0;
  logic [10:0] irq_clr = '0;
  logic [10:0] gpi_pin, irq_st;
  logic [3:0] lag = 4'h0;
  logic [3:0] ev_id;
  logic flag, push, ev_state, unlock_ok, ev_irq;
  logic [4:0] pu300, pd300, pu100;
  logic [4:0] ev_q[$];
  int err_count = 0;
  int tests_run = 0;
  // address, write data, expected read back
  logic [23:0] rows[8] = '{24'h19ffff, 24'h1aff03, 24'h1bff3f, 24'h1cff1f,
    24'h1dff3f, 24'h1eff1f, 24'h20ff00, 24'h19e4e4};

  gpicfg_pin_model u_gpicfg_pin_model (.clk(clk), .target(target), .lag(lag), .pin(gpi_pin));
  gpicfg_core u_gpicfg_core (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpi_pin(gpi_pin),
    .input_irq_enable(irq_en), .input_irq_clear(irq_clr), .input_irq_status(irq_st),
    .general_input_irq_flag(flag), .column_pull_up_300k(pu300), .column_pull_down_300k(pd300),
    .column_pull_up_100k(pu100), .fifo_event_push(push), .fifo_event_input(ev_id),
    .fifo_event_state(ev_state), .fifo_event_unlock_ok(unlock_ok), .event_irq_set(ev_irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim;
    $display("errors %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    `CHK(reg_rdata, e)
  endtask
  // n == 0 waits for any status, otherwise for n queued events
  task automatic wait_ok(input int n);
    for (int i = 0; i < 30; i++) begin
      if (n == 0 ? irq_st !== 11'h0 : ev_q.size() >= n) return;
      @(negedge clk);
    end
    err_count++;
    end_sim();
  endtask
  task automatic clear_all;
    irq_clr = '1;
    tick(1);
    irq_clr = '0;
  endtask

  // the event side outputs must travel with the push pulse
  always @(negedge clk) begin
    if (push === 1'b1) ev_q.push_back({ev_state, ev_id});
    if (srst === 1'b0) `CHK({unlock_ok, ev_irq}, {push, push})
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    tick(5);
    srst = 1'b0;
    `CHK({pu300, pd300, pu100}, 15'h7c00)
    for (int a = 8'h19; a <= 8'h1e; a++) chk_rd(8'(a), 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      chk_rd(rows[i][23:16], rows[i][7:0]);
    end
    `CHK({pu300, pd300, pu100}, 15'h0444)
    for (int c = 0; c < 4; c++) begin
      wr(8'h1a, 8'(c));
      `CHK({pu300[4], pd300[4], pu100[4]}, 3'b100 >> c)
    end
    // level scenario: mixed polarities, slow pins
    wr(8'h1d, 8'h00);
    wr(8'h1e, 8'h00);
    wr(8'h1b, 8'h2a);
    wr(8'h1c, 8'h0a);
    lag = 4'h3;
    irq_en = 11'h555;
    target = 11'h555;
    tick(10);
    clear_all();
    for (int k = 0; k < 11; k++) begin
      target = 11'h555 ^ (11'h1 << k);
      wait_ok(0);
      `CHK(irq_st, 11'h1 << k)
      `CHK(flag, irq_en[k])
      target = 11'h555;
      tick(10);
      clear_all();
    end
    // event scenario: routed inputs 3 and 11 change together with unrouted 5
    lag = 4'h0;
    wr(8'h1b, 8'h00);
    wr(8'h1c, 8'h00);
    target = '1;
    tick(8);
    clear_all();
    wr(8'h1d, 8'h04);
    wr(8'h1e, 8'h10);
    irq_en = 11'h404;
    ev_q.delete();
    target = 11'h3eb;
    wait_ok(2);
    tick(4);
    `CHK(ev_q.size(), 2)
    `CHK(ev_q[0], 5'h03)
    `CHK(ev_q[1], 5'h0b)
    `CHK(irq_st, 11'h010)
    `CHK(flag, 1'b0)
    target = '1;
    wait_ok(4);
    `CHK(ev_q[2], 5'h13)
    `CHK(ev_q[3], 5'h1b)
    // every input routed: levels met and enabled, yet no status and no general flag
    wr(8'h1d, 8'h3f);
    wr(8'h1e, 8'h1f);
    wr(8'h1b, 8'h3f);
    wr(8'h1c, 8'h1f);
    irq_en = '1;
    tick(3);
    `CHK({irq_st, flag}, 12'h000)
    target = 11'h7fe;
    wait_ok(5);
    `CHK(ev_q[4], 5'h01)
    `CHK({irq_st, flag}, 12'h000)
    // reset in mid-run restores the defaults
    srst = 1'b1;
    tick(5);
    srst = 1'b0;
    chk_rd(8'h1d, 8'h00);
    `CHK(pu300, 5'h1f)
    end_sim();
  end
endmodule
